/* tb/esp_remote_node.sv */
`timescale 1ns/1ps
module esp_remote_node #(
    parameter int BIT = 32
) (
    input  wire logic pclk,
    input  wire logic nine,
    input  wire logic tx_line,
    output logic      rx_line
);
    logic [8:0] sh;
    logic [7:0] rx_data;
    logic       rx_ninth;
    int         got;
    initial rx_line = 1'b1;
    initial got = 0;
    // Stop level is a parameter of the call to provoke framing faults
    task automatic send(input logic [7:0] d, input logic n9, input logic stp);
        logic [10:0] f;
        f = nine ? {stp, n9, d, 1'b0} : {1'b1, stp, d, 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            rx_line <= f[i];
            repeat (BIT) @(posedge pclk);
        end
        rx_line <= 1'b1;
        repeat (BIT) @(posedge pclk);
    endtask
    // Mid-bit sampling; ninth sample is the stop bit in 8-bit frames
    always begin
        @(negedge tx_line);
        repeat (BIT / 2) @(posedge pclk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge pclk);
            sh[i] = tx_line;
        end
        rx_data = sh[7:0];
        rx_ninth = sh[8];
        got = got + 1;
    end
endmodule

/* tb/esp_serial_core_bench.sv */
`timescale 1ns/1ps
module esp_serial_core_bench;
    import esp_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq, tx_pin, rx_out, rx_oe, node_rx, rx_wire;
    logic [31:0] q;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cyc = 0;
    always #12.5 pclk = ~pclk;
    // Open drain with pull-up: only a zero is ever driven
    assign rx_wire = node_rx & ~rx_oe;
    esp_serial_core i_esp_serial_core (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .serial_tx_pin(tx_pin), .serial_rx_pin_in(rx_wire),
        .serial_rx_pin_out(rx_out), .serial_rx_pin_oe(rx_oe));
    esp_remote_node #(.BIT(32)) i_esp_remote_node (.pclk(pclk), .nine(1'b1),
        .tx_line(tx_pin), .rx_line(node_rx));
    task test_done;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares = miscompares + 1;
            test_done;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One idle cycle after each transfer keeps every signal single-driven
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    task wait_st(input int b);
        q = 32'h0;
        for (int k = 0; k < 400 && q[b] !== 1'b1; k++) apb(1'b0, ADDR_STAT, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
        rd(ADDR_STAT, 32'hFFFFFFFF, 32'h0);
        rd(ADDR_MATCH, 32'hFFFFFFFF, 32'h0000FF00);
        rd(ADDR_IEN, 32'hFFFFFFFF, 32'h0);
        rd(ADDR_CLR, 32'hFFFFFFFF, 32'h0);
        rd(8'h1C, 32'hFFFFFFFF, 32'h0);
        chk({31'h0, pslverr}, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h198); // Mode 2, clk/32, receive on, ninth 1
        apb(1'b1, ADDR_IEN, 32'h3);
        apb(1'b1, ADDR_DATA, 32'hA5);
        wait_st(ST_TX_DONE);
        rd(ADDR_STAT, 32'h12, 32'h12);
        chk({15'h0, i_esp_remote_node.got[7:0], i_esp_remote_node.rx_ninth,
             i_esp_remote_node.rx_data}, 32'h3A5);
        chk({31'h0, irq}, 32'h1);
        rd(ADDR_CTRL, 32'h2, 32'h2);
        apb(1'b1, ADDR_CLR, 32'h2);
        chk({31'h0, irq}, 32'h0);
        i_esp_remote_node.send(8'h3C, 1'b0, 1'b1);
        wait_st(ST_RX_DONE);
        rd(ADDR_DATA, 32'hFFFFFFFF, 32'h3C);
        rd(ADDR_CTRL, 32'h7, 32'h1);
        chk({31'h0, irq}, 32'h1);
        i_esp_remote_node.send(8'h77, 1'b1, 1'b1);
        rd(ADDR_DATA, 32'hFF, 32'h3C);
        apb(1'b1, ADDR_CLR, 32'h1);
        i_esp_remote_node.send(8'h5A, 1'b1, 1'b1);
        wait_st(ST_RX_DONE);
        rd(ADDR_CTRL, 32'h7, 32'h5);
        rd(ADDR_STAT, 32'h4, 32'h0);
        apb(1'b1, ADDR_CLR, 32'h1);
        i_esp_remote_node.send(8'h11, 1'b0, 1'b1);
        wait_st(ST_RX_DONE);
        rd(ADDR_STAT, 32'h5, 32'h5);
        rd(ADDR_DATA, 32'hFF, 32'h11);
        rd(ADDR_STAT, 32'h4, 32'h4);
        apb(1'b1, ADDR_CLR, 32'h5);
        rd(ADDR_STAT, 32'h5, 32'h0);
        i_esp_remote_node.send(8'h22, 1'b0, 1'b0);
        rd(ADDR_STAT, 32'h8, 32'h8);
        apb(1'b1, ADDR_CLR, 32'hF);
        apb(1'b1, ADDR_MATCH, 32'h0000FF42);
        apb(1'b1, ADDR_CTRL, 32'h1B8); // Address check on
        i_esp_remote_node.send(8'h42, 1'b0, 1'b1);
        i_esp_remote_node.send(8'h43, 1'b1, 1'b1);
        rd(ADDR_STAT, 32'h1, 32'h0);
        i_esp_remote_node.send(8'h42, 1'b1, 1'b1);
        wait_st(ST_RX_DONE);
        rd(ADDR_DATA, 32'hFF, 32'h42);
        apb(1'b1, ADDR_CLR, 32'hF);
        apb(1'b1, ADDR_CTRL, 32'h0); // Sync mode, receiver off
        apb(1'b1, ADDR_DATA, 32'h96);
        wait_st(ST_TX_DONE);
        rd(ADDR_STAT, 32'h3, 32'h2);
        apb(1'b1, ADDR_CTRL, 32'h10); // Sync receive from the pulled-up line
        wait_st(ST_RX_DONE);
        rd(ADDR_DATA, 32'hFF, 32'hFF);
        test_done;
    end
endmodule

/* tb/esp_serial_core_properties.sv */
`timescale 1ns/1ps
module esp_serial_core_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        serial_tx_pin,
    input wire logic        serial_rx_pin_in,
    input wire logic        serial_rx_pin_out,
    input wire logic        serial_rx_pin_oe
);
    import esp_pkg::*;
    logic mapped;
    logic clr_wr;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= ADDR_BAUD);
    // Only these writes may drop a flag or an enable, so irq must hold otherwise
    assign clr_wr = psel && penable && pwrite && (paddr == ADDR_CLR || paddr == ADDR_IEN);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_rd(logic [7:0] a);
        s_setup ##0 (!pwrite && paddr == a);
    endsequence
    a_ready_high: assert property (pready) else $error("pready low");
    a_drain_low: assert property (!serial_rx_pin_out) else $error("rx out high");
    a_err_unmapped: assert property (s_setup ##0 !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped not refused");
    a_err_mapped: assert property (s_setup ##0 mapped |=> !pslverr)
        else $error("mapped refused");
    a_err_stands: assert property (!(psel && !penable) |=> $stable(pslverr))
        else $error("pslverr moved");
    a_write_zero: assert property (s_setup ##0 pwrite |=> prdata == 32'h0)
        else $error("write returned data");
    a_clr_zero: assert property (s_rd(ADDR_CLR) |=> prdata == 32'h0)
        else $error("clear reg readable");
    a_ctrl_width: assert property (s_rd(ADDR_CTRL) |=> prdata[31:9] == 23'h0)
        else $error("ctrl upper bits");
    a_stat_width: assert property (s_rd(ADDR_STAT) |=> prdata[31:6] == 26'h0)
        else $error("status upper bits");
    a_data_width: assert property (s_rd(ADDR_DATA) |=> prdata[31:8] == 24'h0)
        else $error("data upper bits");
    a_irq_sticky: assert property (irq && !clr_wr |=> irq)
        else $error("irq dropped by itself");
endmodule
bind esp_serial_core esp_serial_core_properties i_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .serial_tx_pin(serial_tx_pin), .serial_rx_pin_in(serial_rx_pin_in),
    .serial_rx_pin_out(serial_rx_pin_out), .serial_rx_pin_oe(serial_rx_pin_oe));

/* verilog/esp_async_rx.sv */
`timescale 1ns/1ps
module esp_async_rx #(
    parameter int OVERSAMPLE = esp_pkg::OVERSAMPLE
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                enable,
    input  wire logic                nine,
    input  wire logic                os_tick,
    input  wire logic                rx_in,
    output esp_pkg::esp_frame_t      frame,
    output logic                     frame_valid,
    output logic                     busy
);
    import esp_pkg::*;

    if (OVERSAMPLE < 4 || OVERSAMPLE > 16) begin : g_bad_os
        $error("esp_async_rx: OVERSAMPLE must be 4 to 16");
    end

    localparam logic [3:0] LAST = 4'(OVERSAMPLE - 1);
    localparam logic [3:0] MID  = 4'(OVERSAMPLE / 2);

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} esp_rx_st_t;

    typedef struct packed {
        esp_rx_st_t st;
        logic [3:0] cnt;
        logic [3:0] bitn;
        logic [8:0] sh;
        logic [2:0] smp;
        logic       prev;
        esp_frame_t frame;
        logic       valid;
    } esp_rx_state_t;

    esp_rx_state_t state;
    esp_rx_state_t next_state;

    function automatic logic vote(input logic [2:0] s);
        vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    always_comb begin
        logic bitv;
        bitv             = vote(state.smp);
        next_state       = state;
        next_state.valid = 1'b0;
        next_state.prev  = rx_in;
        if (!enable) begin
            next_state.st = RX_IDLE;
        end else if (state.st == RX_IDLE) begin
            if (state.prev && !rx_in) begin
                next_state.st  = RX_START;
                next_state.cnt = 4'h0;
            end
        end else if (os_tick) begin
            next_state.cnt = state.cnt + 4'h1;
            // Three-sample vote rides out a short glitch
            if (state.cnt >= MID - 4'h1 && state.cnt <= MID + 4'h1) begin
                next_state.smp = {state.smp[1:0], rx_in};
            end
            if (state.cnt == LAST) begin
                next_state.cnt = 4'h0;
                unique case (state.st)
                    RX_START: begin
                        next_state.st   = bitv ? RX_IDLE : RX_DATA;
                        next_state.bitn = 4'h0;
                    end
                    RX_DATA: begin
                        next_state.sh   = {bitv, state.sh[8:1]};
                        next_state.bitn = state.bitn + 4'h1;
                        if (state.bitn == (nine ? 4'h8 : 4'h7)) begin
                            next_state.st = RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        next_state.st          = RX_IDLE;
                        next_state.valid       = 1'b1;
                        next_state.frame.stop  = bitv;
                        next_state.frame.data  = nine ? state.sh[7:0] : state.sh[8:1];
                        next_state.frame.ninth = nine ? state.sh[8] : bitv;
                    end
                    default: next_state.st = RX_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= '0;
            state.prev <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign frame       = state.frame;
    assign frame_valid = state.valid;
    assign busy        = (state.st != RX_IDLE);

endmodule

/* verilog/esp_baud_gen.sv */
`timescale 1ns/1ps
module esp_baud_gen (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire esp_pkg::esp_mode_t mode,
    input  wire logic              dbl,
    input  wire logic [15:0]       reload,
    output logic                   os_tick,
    output logic                   half_tick
);
    import esp_pkg::*;

    typedef struct packed {
        logic [15:0] tmr;
        logic        ovf_half;
        logic [1:0]  pre;
        logic [2:0]  m0cnt;
        logic        os_tick;
        logic        half_tick;
    } esp_baud_state_t;

    esp_baud_state_t state;
    esp_baud_state_t next_state;

    always_comb begin
        next_state           = state;
        next_state.os_tick   = 1'b0;
        next_state.half_tick = 1'b0;
        // Sync shift clock: two halves of six clocks
        if (state.m0cnt == 3'(M0_HALF_CLKS - 1)) begin
            next_state.m0cnt     = 3'h0;
            next_state.half_tick = 1'b1;
        end else begin
            next_state.m0cnt = state.m0cnt + 3'h1;
        end
        if (mode == ESP_MODE_FIXED9) begin
            if (state.pre >= (dbl ? 2'(M2_DIV_DBL - 1) : 2'(M2_DIV - 1))) begin
                next_state.pre     = 2'h0;
                next_state.os_tick = 1'b1;
            end else begin
                next_state.pre = state.pre + 2'h1;
            end
        end else begin
            // Internal reload timer stands in for the overflow source
            if (state.tmr == 16'hFFFF) begin
                next_state.tmr      = reload;
                next_state.ovf_half = ~state.ovf_half;
                next_state.os_tick  = dbl | state.ovf_half;
            end else begin
                next_state.tmr = state.tmr + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign os_tick   = state.os_tick;
    assign half_tick = state.half_tick;

endmodule

/* verilog/esp_pkg.sv */
// Functional notes
// - Async full-duplex and sync half-duplex, multiprocessor
// - Detect framing errors and match node addresses
// - Received byte moves to separate holding register
// - Flag overrun when unread byte is overwritten
// - Data buffer: write transmits, read returns received
// - Transmit-done flag at control bit 1
// - Receive-done flag at control bit 0
// - Two interrupt sources: transmit and receive done
// - Flags cleared only by software, never hardware
// - Four modes, sync /12, fixed /32 /64
// - Sync mode: data on rx pin, clock out
// - Store only if flag clear; stop ok needed only in mode 1 with mpc set
// - Async transmit-done set at stop bit start
package esp_pkg;

    typedef enum logic [1:0] {
        ESP_MODE_SYNC,
        ESP_MODE_ASYNC8,
        ESP_MODE_FIXED9,
        ESP_MODE_VAR9
    } esp_mode_t;

    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
        logic       stop;
    } esp_frame_t;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int OVERSAMPLE   = 16;
    localparam int M0_BIT_CLKS  = 12;
    localparam int M0_HALF_CLKS = M0_BIT_CLKS / 2;
    localparam int M2_DIV_DBL   = 32 / OVERSAMPLE;
    localparam int M2_DIV       = 64 / OVERSAMPLE;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_DATA  = 8'h04;
    localparam logic [7:0] ADDR_STAT  = 8'h08;
    localparam logic [7:0] ADDR_CLR   = 8'h0C;
    localparam logic [7:0] ADDR_IEN   = 8'h10;
    localparam logic [7:0] ADDR_MATCH = 8'h14;
    localparam logic [7:0] ADDR_BAUD  = 8'h18;

    // Control register fields
    localparam int CTRL_RX_DONE = 0;
    localparam int CTRL_TX_DONE = 1;
    localparam int CTRL_RX_NINE = 2;
    localparam int CTRL_TX_NINE = 3;
    localparam int CTRL_RX_EN   = 4;
    localparam int CTRL_MPC     = 5;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_DBL     = 8;

    // Status, clear and enable layout
    localparam int ST_RX_DONE = 0;
    localparam int ST_TX_DONE = 1;
    localparam int ST_OVERRUN = 2;
    localparam int ST_FRAME   = 3;
    localparam int ST_TX_BUSY = 4;
    localparam int ST_RX_BUSY = 5;

    // Reset values
    localparam logic [15:0] BAUD_RST  = 16'h0000;
    localparam logic [7:0]  ADDR_RST  = 8'h00;
    localparam logic [7:0]  AMASK_RST = 8'hFF;
    localparam logic [1:0]  IEN_RST   = 2'h0;

endpackage

/* verilog/esp_serial_core.sv */
`timescale 1ns/1ps
module esp_serial_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             serial_tx_pin,
    input  wire logic        serial_rx_pin_in,
    output logic             serial_rx_pin_out,
    output logic             serial_rx_pin_oe
);
    import esp_pkg::*;

    localparam logic [3:0] OS_LAST = 4'(OVERSAMPLE - 1);

    typedef struct packed {
        esp_mode_t   mode;
        logic        mpc;
        logic        ren;
        logic        tb8;
        logic        dbl;
        logic        rb8;
        logic        rx_flag;
        logic        tx_flag;
        logic        ovr;
        logic        ferr;
        logic        unread;
        logic [1:0]  ien;
        logic [7:0]  rbuf;
        logic [7:0]  addr;
        logic [7:0]  amask;
        logic [15:0] reload;
        logic [31:0] prdata;
        logic        pslverr;
        logic        tx_busy;
        logic [9:0]  tx_sh;
        logic [3:0]  tx_left;
        logic [3:0]  tx_cnt;
        logic        tx_pin;
        logic        m0_busy;
        logic        m0_rx;
        logic        m0_phase;
        logic [3:0]  m0_bits;
        logic [7:0]  m0_sh;
        logic        m0_clk;
        logic        m0_dout;
        logic        m0_fin;
    } esp_core_state_t;

    esp_core_state_t state;
    esp_core_state_t next_state;

    logic       os_tick;
    logic       half_tick;
    esp_frame_t rx_frame;
    logic       rx_valid;
    logic       rx_busy;
    logic       async_mode;
    logic       nine_mode;

    assign async_mode = (state.mode != ESP_MODE_SYNC);
    assign nine_mode  = (state.mode == ESP_MODE_FIXED9) || (state.mode == ESP_MODE_VAR9);

    ////////////////////////////////////////////////////////////////////////////
    // Rate generation and async receiver
    esp_baud_gen u_baud (
        .pclk      (pclk),
        .presetn   (presetn),
        .mode      (state.mode),
        .dbl       (state.dbl),
        .reload    (state.reload),
        .os_tick   (os_tick),
        .half_tick (half_tick)
    );

    esp_async_rx #(
        .OVERSAMPLE (OVERSAMPLE)
    ) u_rx (
        .pclk        (pclk),
        .presetn     (presetn),
        .enable      (state.ren && async_mode),
        .nine        (nine_mode),
        .os_tick     (os_tick),
        .rx_in       (serial_rx_pin_in),
        .frame       (rx_frame),
        .frame_valid (rx_valid),
        .busy        (rx_busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register and serial logic
    always_comb begin
        logic        setup;
        logic        wr;
        logic        rd;
        logic        mapped;
        logic        accept;
        logic        match;
        logic [31:0] rdata;
        logic [5:0]  sticky;
        setup      = psel && !penable;
        wr         = psel && penable && pwrite;
        rd         = psel && penable && !pwrite;
        mapped     = 1'b0;
        accept     = 1'b0;
        rdata      = 32'h0000_0000;
        next_state = state;
        match      = ((rx_frame.data ^ state.addr) & state.amask) == 8'h00;

        // Read data is captured in the setup cycle, so the access needs no wait
        sticky = {rx_busy || (state.m0_busy && state.m0_rx),
                  state.tx_busy || (state.m0_busy && !state.m0_rx),
                  state.ferr, state.ovr, state.tx_flag, state.rx_flag};
        unique case (paddr)
            ADDR_CTRL: begin
                mapped = 1'b1;
                rdata  = {23'h000000, state.dbl, state.mode, state.mpc, state.ren,
                          state.tb8, state.rb8, state.tx_flag, state.rx_flag};
            end
            ADDR_DATA: begin
                mapped = 1'b1;
                rdata  = {24'h000000, state.rbuf};
            end
            ADDR_STAT: begin
                mapped = 1'b1;
                rdata  = {26'h0000000, sticky};
            end
            ADDR_CLR: begin
                mapped = 1'b1;
            end
            ADDR_IEN: begin
                mapped = 1'b1;
                rdata  = {30'h00000000, state.ien};
            end
            ADDR_MATCH: begin
                mapped = 1'b1;
                rdata  = {16'h0000, state.amask, state.addr};
            end
            ADDR_BAUD: begin
                mapped = 1'b1;
                rdata  = {16'h0000, state.reload};
            end
            default: mapped = 1'b0;
        endcase
        if (setup) begin
            next_state.prdata  = pwrite ? 32'h0000_0000 : rdata;
            next_state.pslverr = !mapped;
        end

        // Register writes; flags never cleared here by hardware
        if (wr && paddr == ADDR_CTRL) begin
            next_state.tb8  = pwdata[CTRL_TX_NINE];
            next_state.ren  = pwdata[CTRL_RX_EN];
            next_state.mpc  = pwdata[CTRL_MPC];
            next_state.mode = esp_mode_t'(pwdata[CTRL_MODE_LO +: 2]);
            next_state.dbl  = pwdata[CTRL_DBL];
        end
        if (wr && paddr == ADDR_CLR) begin
            // Software is the only path that clears these
            if (pwdata[ST_RX_DONE]) next_state.rx_flag = 1'b0;
            if (pwdata[ST_TX_DONE]) next_state.tx_flag = 1'b0;
            if (pwdata[ST_OVERRUN]) next_state.ovr = 1'b0;
            if (pwdata[ST_FRAME]) next_state.ferr = 1'b0;
        end
        if (wr && paddr == ADDR_IEN) begin
            next_state.ien = pwdata[1:0];
        end
        if (wr && paddr == ADDR_MATCH) begin
            next_state.addr  = pwdata[7:0];
            next_state.amask = pwdata[15:8];
        end
        if (wr && paddr == ADDR_BAUD) begin
            next_state.reload = pwdata[15:0];
        end
        // Reading the buffer marks it consumed but leaves overrun alone
        if (rd && paddr == ADDR_DATA) begin
            next_state.unread = 1'b0;
        end

        // Async transmit; a write while busy is dropped
        if (wr && paddr == ADDR_DATA && async_mode && !state.tx_busy) begin
            next_state.tx_busy = 1'b1;
            next_state.tx_pin  = 1'b0;
            next_state.tx_cnt  = 4'h0;
            next_state.tx_sh   = {1'b1, nine_mode ? state.tb8 : 1'b1, pwdata[7:0]};
            next_state.tx_left = nine_mode ? 4'hA : 4'h9;
        end else if (state.tx_busy && os_tick) begin
            next_state.tx_cnt = state.tx_cnt + 4'h1;
            if (state.tx_cnt == OS_LAST) begin
                next_state.tx_cnt = 4'h0;
                if (state.tx_left == 4'h0) begin
                    next_state.tx_busy = 1'b0;
                end else begin
                    next_state.tx_pin  = state.tx_sh[0];
                    next_state.tx_sh   = {1'b1, state.tx_sh[9:1]};
                    next_state.tx_left = state.tx_left - 4'h1;
                    // Flag rises as the stop bit begins, not at its end
                    if (state.tx_left == 4'h1) next_state.tx_flag = 1'b1;
                end
            end
        end
        if (!async_mode && !state.tx_busy) begin
            next_state.tx_pin = 1'b1;
        end

        // Synchronous shifter; data on the rx pin, clock on the tx pin
        next_state.m0_fin = 1'b0;
        if (!async_mode && !state.m0_busy) begin
            next_state.m0_clk  = 1'b1;
            next_state.m0_dout = 1'b1;
            if (wr && paddr == ADDR_DATA) begin
                next_state.m0_busy  = 1'b1;
                next_state.m0_rx    = 1'b0;
                next_state.m0_phase = 1'b0;
                next_state.m0_bits  = 4'h0;
                next_state.m0_sh    = pwdata[7:0];
            end else if (state.ren && !state.rx_flag && !state.m0_fin) begin
                next_state.m0_busy  = 1'b1;
                next_state.m0_rx    = 1'b1;
                next_state.m0_phase = 1'b0;
                next_state.m0_bits  = 4'h0;
            end
        end else if (state.m0_busy && half_tick) begin
            next_state.m0_phase = ~state.m0_phase;
            if (!state.m0_phase) begin
                next_state.m0_clk  = 1'b0;
                next_state.m0_dout = state.m0_rx ? 1'b1 : state.m0_sh[0];
            end else begin
                next_state.m0_clk  = 1'b1;
                next_state.m0_bits = state.m0_bits + 4'h1;
                // LSB first in both directions
                next_state.m0_sh = state.m0_rx ? {serial_rx_pin_in, state.m0_sh[7:1]}
                                               : {1'b1, state.m0_sh[7:1]};
                if (state.m0_bits == 4'h7) begin
                    next_state.m0_busy = 1'b0;
                    next_state.m0_fin  = state.m0_rx;
                    if (!state.m0_rx) next_state.tx_flag = 1'b1;
                end
            end
        end
        if (async_mode) begin
            next_state.m0_busy = 1'b0;
        end

        // Completed sync byte lands one cycle after its eighth bit
        if (state.m0_fin) begin
            next_state.rbuf    = state.m0_sh;
            next_state.rx_flag = 1'b1;
            next_state.unread  = 1'b1;
            if (state.unread) next_state.ovr = 1'b1;
        end

        // Async receive acceptance; set wins over a same-cycle clear
        if (rx_valid) begin
            if (!rx_frame.stop) next_state.ferr = 1'b1;
            if (state.mode == ESP_MODE_ASYNC8) begin
                accept = !state.rx_flag && (!state.mpc || rx_frame.stop);
            end else begin
                accept = !state.rx_flag && (!state.mpc || (rx_frame.ninth && match));
            end
            if (accept) begin
                next_state.rbuf    = rx_frame.data;
                next_state.rb8     = rx_frame.ninth;
                next_state.rx_flag = 1'b1;
                next_state.unread  = 1'b1;
                if (state.unread) next_state.ovr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state         <= '0;
            state.mode    <= ESP_MODE_SYNC;
            state.addr    <= ADDR_RST;
            state.amask   <= AMASK_RST;
            state.reload  <= BAUD_RST;
            state.ien     <= IEN_RST;
            state.tx_pin  <= 1'b1;
            state.m0_clk  <= 1'b1;
            state.m0_dout <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata  = state.prdata;
    assign pready  = 1'b1;
    assign pslverr = state.pslverr;
    // Two sources only, merged onto one line
    assign irq = |({state.tx_flag, state.rx_flag} & state.ien);

    // Open-drain in sync mode: only ever pulls low
    assign serial_tx_pin     = async_mode ? state.tx_pin : state.m0_clk;
    assign serial_rx_pin_out = 1'b0;
    assign serial_rx_pin_oe  = !async_mode && state.m0_busy && !state.m0_dout;

endmodule
